// ==== rtl/pcl_loader.sv ====
// pcl_loader: status, strap decode and teardown counter for link config
// assumes: apb master on clk_sys, control block signals asynchronous
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pcl_loader
  import pcl_pkg::*;
(
  input wire logic clk_sys, // 50 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [7:0] strap_in, // debug strap bus
  input wire pcl_pkg::pcl_ctrl_type ctrl_in, // control block status
  input wire logic [3:0] ltssm_in, // link training state
  output pcl_pkg::pcl_hard_type hard_out, // decoded strap controls
  output logic link_up, // link reached L0
  output logic teardown_done, // dummy write count reached
  output logic irq // level interrupt
);
  import pcl_pkg::*;

  // -------------------------------------------------------------------
  // synchronisers for the asynchronous control block inputs
  // -------------------------------------------------------------------
  localparam int NS = $bits(pcl_ctrl_type);
  logic [NS-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
  logic [NS-1:0] stat_q, stat_d;
  always_comb begin
    s1_d = ctrl_in;
    s2_d = s1_q;
    s3_d = s2_q;
    stat_d = (s2_q == s3_q) ? s3_q : stat_q;
    if (!rst_n) begin
      s1_d = '0;
      s2_d = '0;
      s3_d = '0;
      stat_d = '0;
    end
  end
  always_ff @(posedge clk_sys) begin
    s1_q <= s1_d;
    s2_q <= s2_d;
    s3_q <= s3_d;
    stat_q <= stat_d;
  end
  pcl_ctrl_type st;
  assign st = pcl_ctrl_type'(stat_q);

  // -------------------------------------------------------------------
  // strap and link state, same-domain registered
  // -------------------------------------------------------------------
  logic [7:0] strap_q, strap_d;
  logic [3:0] ltssm_q, ltssm_d;
  pcl_hard_type hard_d, hard_q;
  logic l0_q, l0_d;
  always_comb begin
    strap_d = strap_in;
    ltssm_d = ltssm_in;
    hard_d.lowpwr_allowed = !strap_q[PCL_STRAP_NO_LOWPWR];
    hard_d.compliance_allowed = !strap_q[PCL_STRAP_NO_COMPL];
    hard_d.in_pld = strap_q[PCL_STRAP_IN_PLD];
    l0_d = (ltssm_q == PCL_LTSSM_L0);
    if (!rst_n) begin
      strap_d = '0;
      ltssm_d = '0;
      hard_d = '0;
      l0_d = 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    strap_q <= strap_d;
    ltssm_q <= ltssm_d;
    hard_q <= hard_d;
    l0_q <= l0_d;
  end
  assign hard_out = hard_q;
  assign link_up = l0_q;

  // -------------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------------
  logic acc, wr, known;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      PCL_ADDR_STATUS, PCL_ADDR_DATA, PCL_ADDR_IRQ_STAT,
      PCL_ADDR_IRQ_MASK, PCL_ADDR_LINK, PCL_ADDR_STRAP,
      PCL_ADDR_DCOUNT: known = 1'b1;
      default: known = 1'b0;
    endcase
  end
  assign pslverr = acc && !known;

  // -------------------------------------------------------------------
  // teardown dummy write counter
  // -------------------------------------------------------------------
  logic [7:0] dcnt_q, dcnt_d;
  logic tdone_q, tdone_d;
  logic dummy;
  assign dummy = wr && (paddr == PCL_ADDR_DATA) && st.enabled;
  always_comb begin
    dcnt_d = dcnt_q;
    tdone_d = tdone_q;
    if (dummy && !tdone_q) begin
      dcnt_d = dcnt_q + 8'h01;
      if (dcnt_d == PCL_TEARDOWN_WRITES) begin
        tdone_d = 1'b1;
      end
    end
    if (!st.enabled) begin
      dcnt_d = '0;
      tdone_d = 1'b0;
    end
    if (!rst_n) begin
      dcnt_d = '0;
      tdone_d = 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    dcnt_q <= dcnt_d;
    tdone_q <= tdone_d;
  end
  assign teardown_done = tdone_q;

  // -------------------------------------------------------------------
  // interrupt status and mask
  // -------------------------------------------------------------------
  logic [PCL_IRQ_N-1:0] ist_q, ist_d, imask_q, imask_d, ev;
  logic en_dly_q, err_dly_q, l0_dly_q, td_dly_q;
  logic en_dly_d, err_dly_d, l0_dly_d, td_dly_d;
  always_comb begin
    ev = '0;
    ev[PCL_IRQ_EN] = st.enabled && !en_dly_q;
    ev[PCL_IRQ_ERR] = st.cfg_error && !err_dly_q;
    ev[PCL_IRQ_L0] = l0_q && !l0_dly_q;
    ev[PCL_IRQ_TEARDOWN] = tdone_q && !td_dly_q;
    en_dly_d = st.enabled;
    err_dly_d = st.cfg_error;
    l0_dly_d = l0_q;
    td_dly_d = tdone_q;
    imask_d = imask_q;
    ist_d = ist_q;
    if (wr && paddr == PCL_ADDR_IRQ_STAT) begin
      ist_d = ist_q & ~pwdata[PCL_IRQ_N-1:0];
    end
    ist_d = ist_d | ev;
    if (wr && paddr == PCL_ADDR_IRQ_MASK) begin
      imask_d = pwdata[PCL_IRQ_N-1:0];
    end
    if (!rst_n) begin
      ist_d = '0;
      imask_d = '0;
      en_dly_d = 1'b0;
      err_dly_d = 1'b0;
      l0_dly_d = 1'b0;
      td_dly_d = 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    ist_q <= ist_d;
    imask_q <= imask_d;
    en_dly_q <= en_dly_d;
    err_dly_q <= err_dly_d;
    l0_dly_q <= l0_dly_d;
    td_dly_q <= td_dly_d;
  end
  assign irq = |(ist_q & imask_q);

  // -------------------------------------------------------------------
  // read data
  // -------------------------------------------------------------------
  logic [31:0] rd_q, rd_d;
  always_comb begin
    rd_d = PCL_ZERO;
    case (paddr)
      PCL_ADDR_STATUS: begin
        rd_d[PCL_BIT_CFG_DONE] = st.cfg_done;
        rd_d[PCL_BIT_USERMODE] = st.usermode;
        rd_d[PCL_BIT_EN] = st.enabled;
        rd_d[PCL_BIT_CFG_ERR] = st.cfg_error;
        rd_d[PCL_BIT_CFG_RDY] = st.cfg_ready;
      end
      PCL_ADDR_IRQ_STAT: rd_d[PCL_IRQ_N-1:0] = ist_q;
      PCL_ADDR_IRQ_MASK: rd_d[PCL_IRQ_N-1:0] = imask_q;
      PCL_ADDR_LINK: begin
        rd_d[3:0] = ltssm_q;
        rd_d[PCL_LINK_L0_BIT] = l0_q;
      end
      PCL_ADDR_STRAP: rd_d[7:0] = strap_q;
      PCL_ADDR_DCOUNT: begin
        rd_d[7:0] = dcnt_q;
        rd_d[PCL_DCNT_DONE_BIT] = tdone_q;
      end
      default: rd_d = PCL_ZERO;
    endcase
    if (!(psel && !penable && !pwrite)) begin
      rd_d = rd_q;
    end
    if (!rst_n) begin
      rd_d = PCL_ZERO;
    end
  end
  always_ff @(posedge clk_sys) begin
    rd_q <= rd_d;
  end
  assign prdata = rd_q;
endmodule : pcl_loader
`default_nettype wire

// ==== rtl/pcl_pkg.sv ====
// pcl_pkg: constants and carrier types for the link configuration loader
// assumes: apb slave with 32-bit data, single clock domain
package pcl_pkg;
  // -------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------
  localparam logic [11:0] PCL_ADDR_STATUS = 12'h21C;
  localparam logic [11:0] PCL_ADDR_DATA = 12'h228;
  localparam logic [11:0] PCL_ADDR_IRQ_STAT = 12'h300;
  localparam logic [11:0] PCL_ADDR_IRQ_MASK = 12'h304;
  localparam logic [11:0] PCL_ADDR_LINK = 12'h308;
  localparam logic [11:0] PCL_ADDR_STRAP = 12'h30C;
  localparam logic [11:0] PCL_ADDR_DCOUNT = 12'h310;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int PCL_BIT_CFG_DONE = 23;
  localparam int PCL_BIT_USERMODE = 21;
  localparam int PCL_BIT_EN = 20;
  localparam int PCL_BIT_CFG_ERR = 19;
  localparam int PCL_BIT_CFG_RDY = 18;
  localparam int PCL_STRAP_NO_LOWPWR = 7;
  localparam int PCL_STRAP_NO_COMPL = 5;
  localparam int PCL_STRAP_IN_PLD = 3;
  localparam int PCL_LINK_L0_BIT = 4;
  localparam int PCL_DCNT_DONE_BIT = 8;
  // irq bit positions
  localparam int PCL_IRQ_EN = 0;
  localparam int PCL_IRQ_ERR = 1;
  localparam int PCL_IRQ_L0 = 2;
  localparam int PCL_IRQ_TEARDOWN = 3;
  localparam int PCL_IRQ_N = 4;
  // -------------------------------------------------------------------
  // values
  // -------------------------------------------------------------------
  localparam logic [7:0] PCL_STRAP_VALUE = 8'hA8;
  localparam logic [3:0] PCL_LTSSM_L0 = 4'hF;
  localparam logic [7:0] PCL_TEARDOWN_WRITES = 8'hF4; // 244 dummy writes
  localparam logic [31:0] PCL_ZERO = 32'h0000_0000;
  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    PCL_LOWPWR_OK,
    PCL_LOWPWR_ENTER
  } pcl_pm_type;
  typedef struct packed {
    logic cfg_done;
    logic usermode;
    logic enabled;
    logic cfg_error;
    logic cfg_ready;
  } pcl_ctrl_type;
  typedef struct packed {
    logic lowpwr_allowed;
    logic compliance_allowed;
    logic in_pld;
  } pcl_hard_type;
endpackage : pcl_pkg

// ==== test/pcl_host.sv ====
// host model: apb master and driver steps
// assumes: clk_sys shared with the loader
`timescale 1ns/1ps
`default_nettype none
module pcl_host
  import pcl_pkg::*;
(
  input wire logic clk_sys, // clock
  output logic psel, // apb
  output logic penable, // apb
  output logic pwrite, // apb
  output logic [11:0] paddr, // apb
  output logic [31:0] pwdata, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr // apb
);
  // command word: memory space and bus master enable
  localparam logic [15:0] CMD_MEM_BUS = 16'h0006;
  logic [15:0] cmd_reg = 16'h0000;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int i;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      if (pready) break;
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    if (i == 16) begin
      testbench.n_fail++;
      testbench.end_sim();
    end
    @(posedge clk_sys);
  endtask : apb
  // program only once the loader reports enable
  task automatic dummy(input int n);
    logic [31:0] r;
    logic e;
    if (!cmd_reg[1]) cmd_reg = CMD_MEM_BUS;
    apb(1'b0, PCL_ADDR_STATUS, PCL_ZERO, r, e);
    if (r[PCL_BIT_EN] && cmd_reg[1])
      repeat (n) apb(1'b1, PCL_ADDR_DATA, PCL_ZERO, r, e);
  endtask : dummy
endmodule : pcl_host
`default_nettype wire

// ==== test/pcl_loader_sva.sv ====
// checker: port relations of pcl_loader
// assumes: bound into pcl_loader, one clock
`timescale 1ns/1ps
`default_nettype none
module pcl_chk
  import pcl_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [11:0] paddr, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pslverr, // apb
  input wire logic [7:0] strap_in, // strap
  input wire pcl_pkg::pcl_ctrl_type ctrl_in, // control
  input wire logic [3:0] ltssm_in, // link state
  input wire pcl_pkg::pcl_hard_type hard_out, // decoded
  input wire logic link_up, // l0
  input wire logic teardown_done // count done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_lp;
    rst_n && strap_in[PCL_STRAP_NO_LOWPWR] |-> ##2
      !hard_out.lowpwr_allowed;
  endproperty
  a_lp: assert property (p_lp) else $error("low power");
  property p_cm;
    rst_n && strap_in[PCL_STRAP_NO_COMPL] |-> ##2
      !hard_out.compliance_allowed;
  endproperty
  a_cm: assert property (p_cm) else $error("compliance");
  property p_pld;
    rst_n && strap_in[PCL_STRAP_IN_PLD] |-> ##2 hard_out.in_pld;
  endproperty
  a_pld: assert property (p_pld) else $error("in pld");
  property p_l0;
    rst_n && ltssm_in == PCL_LTSSM_L0 |-> ##2 link_up;
  endproperty
  a_l0: assert property (p_l0) else $error("l0 missed");
  property p_nl0;
    rst_n && ltssm_in != PCL_LTSSM_L0 |-> ##2 !link_up;
  endproperty
  a_nl0: assert property (p_nl0) else $error("false l0");
  property p_st;
    $stable(ctrl_in)[*6] ##0 (psel && penable && !pwrite
      && paddr == PCL_ADDR_STATUS) |-> prdata[PCL_BIT_EN] ==
      ctrl_in.enabled && prdata[PCL_BIT_CFG_ERR] == ctrl_in.cfg_error;
  endproperty
  a_st: assert property (p_st) else $error("status flags");
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_td;
    $rose(teardown_done) |-> $past(penable) && $past(pwrite)
      && $past(paddr) == PCL_ADDR_DATA;
  endproperty
  a_td: assert property (p_td) else $error("teardown");
endmodule : pcl_chk
bind pcl_loader pcl_chk u_chk (.*);
`default_nettype wire

// ==== test/testbench.sv ====
// bench: strap, link, status and teardown of pcl_loader
// assumes: pcl_host drives the apb side
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pcl_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] strap_in = PCL_STRAP_VALUE;
  // one channel of the omitted controller's tie-off
  localparam logic [63:0] controller_to_transceiver_bus =
    64'h0000_1000_0000_0000;
  pcl_ctrl_type ctrl_in = '0;
  logic [3:0] ltssm_in = 4'h0;
  logic psel, penable, pwrite, pready, pslverr, link_up, teardown_done, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e;
  pcl_hard_type hard_out;
  int n_fail = 0;
  int n_tests = 0;
  pcl_loader dut (.*);
  pcl_host host (.*);
  initial forever #10 clk_sys = ~clk_sys;
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk
  task automatic end_sim();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic t_strap();
    strap_in <= 8'h00;
    repeat (3) @(posedge clk_sys);
    chk(hard_out === 3'b110, "strap clear");
    strap_in <= PCL_STRAP_VALUE;
    repeat (3) @(posedge clk_sys);
    chk(hard_out === 3'b001, "strap set");
    $display("strap test done");
  endtask : t_strap
  task automatic t_link();
    host.apb(1'b1, PCL_ADDR_IRQ_MASK, 32'h0000_0004, r, e);
    ltssm_in <= PCL_LTSSM_L0;
    repeat (6) @(posedge clk_sys);
    chk(link_up === 1'b1 && irq === 1'b1, "l0 irq");
    host.apb(1'b1, PCL_ADDR_IRQ_STAT, 32'h0000_0004, r, e);
    repeat (2) @(posedge clk_sys);
    chk(irq === 1'b0, "irq clear");
    host.apb(1'b1, PCL_ADDR_IRQ_MASK, PCL_ZERO, r, e);
    ltssm_in <= 4'h7;
    repeat (3) @(posedge clk_sys);
    chk(link_up === 1'b0, "not l0");
    ltssm_in <= PCL_LTSSM_L0;
    repeat (6) @(posedge clk_sys);
    host.apb(1'b0, PCL_ADDR_IRQ_STAT, PCL_ZERO, r, e);
    chk(r[PCL_IRQ_L0] === 1'b1 && irq === 1'b0, "masked");
    $display("link test done");
  endtask : t_link
  task automatic t_stat();
    ctrl_in.enabled <= 1'b1;
    ctrl_in.cfg_error <= 1'b1;
    repeat (6) @(posedge clk_sys);
    host.apb(1'b0, PCL_ADDR_STATUS, PCL_ZERO, r, e);
    chk(r[PCL_BIT_EN] === 1'b1, "enable flag");
    chk(r[PCL_BIT_CFG_ERR] === 1'b1, "error flag");
    host.apb(1'b0, 12'h204, PCL_ZERO, r, e);
    chk(e === 1'b1 && r === PCL_ZERO, "unmapped");
    $display("status test done");
  endtask : t_stat
  task automatic t_tear();
    host.dummy(243);
    @(posedge clk_sys);
    chk(teardown_done === 1'b0, "early done");
    host.dummy(1);
    @(posedge clk_sys);
    chk(teardown_done === 1'b1, "done");
    host.apb(1'b0, PCL_ADDR_DCOUNT, PCL_ZERO, r, e);
    chk(r === 32'h0000_01F4, "count");
    host.apb(1'b0, PCL_ADDR_IRQ_STAT, PCL_ZERO, r, e);
    chk(r === 32'h0000_000F && irq === 1'b0, "all events");
    $display("teardown test done");
  endtask : t_tear
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_strap();
    t_link();
    t_stat();
    t_tear();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
